// ### verilog/scs_pkg.sv
package scs_pkg;
	// register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFS_DIV = 4'h0;
	localparam logic [3:0] OFS_FBD = 4'h4;
	localparam logic [3:0] OFS_SRC = 4'h8;
	// clock_divisor_reg field positions
	localparam int RCP_LSB = 8;
	localparam int RCP_MSB = 10;
	localparam int PST_LSB = 6;
	localparam int PST_MSB = 7;
	localparam int PRE_LSB = 0;
	localparam int PRE_MSB = 4;
	// pll_feedback_reg field
	localparam int FBD_MSB = 8;
	// source control register fields
	localparam int REQ_LSB = 0;
	localparam int REQ_MSB = 2;
	localparam int CUR_LSB = 4;
	localparam int BUSY_BIT = 7;
	// reset values
	localparam logic [2:0] RCP_RST = 3'h0;
	localparam logic [1:0] PST_RST = 2'h0;
	localparam logic [4:0] PRE_RST = 5'h00;
	localparam logic [8:0] FBD_RST = 9'h01E;
	// divider arithmetic
	localparam logic [8:0] RC_BASE = 9'h002;
	localparam logic [8:0] RC_DIV16 = 9'h010;
	localparam logic [8:0] PRE_BASE = 9'h002;
	localparam logic [9:0] FBD_BASE = 10'h002;
	localparam logic [8:0] N1_MAX = 9'h021;
	localparam logic [1:0] SH_N2_2 = 2'h1;
	localparam logic [1:0] SH_N2_4 = 2'h2;
	localparam logic [1:0] SH_N2_8 = 2'h3;
	localparam logic [15:0] ACC_MAX = 16'hFFFF;
	// synchronised oscillator pin positions
	localparam int PIN_RC = 0;
	localparam int PIN_PRI = 1;
	localparam int PIN_SEC = 2;
	localparam int PIN_LP = 3;
	// clock sources
	typedef enum logic [2:0] {
		SRC_RC = 3'h0,
		SRC_RC_PLL = 3'h1,
		SRC_PRIMARY = 3'h2,
		SRC_PRIMARY_PLL = 3'h3,
		SRC_SECONDARY = 3'h4,
		SRC_LP_RC = 3'h5,
		SRC_RC_DIV16 = 3'h6,
		SRC_RC_POST = 3'h7
	} scs_src_e;
	// primary oscillator modes
	typedef enum logic [1:0] {
		PM_EXTERNAL = 2'h0,
		PM_STD_XTAL = 2'h1,
		PM_FAST_XTAL = 2'h2,
		PM_OFF = 2'h3
	} scs_pmode_e;
	// switch state machine
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SWITCH = 2'b10
	} scs_state_e;
endpackage

// ### verilog/scs_clock_source.sv
`timescale 1ns/1ps
module scs_clock_source (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [scs_pkg::ADDR_W-1:0] addr_i,
	input wire logic [scs_pkg::DATA_W-1:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [scs_pkg::DATA_W-1:0] rdata_o,
	// non-volatile configuration
	input wire logic [2:0] initial_source_sel_i,
	input wire logic [1:0] primary_mode_sel_i,
	input wire logic osc_pin_function_bit_i,
	// oscillator pins
	input wire logic fast_internal_rc_i,
	input wire logic primary_osc_i,
	input wire logic secondary_osc_i,
	input wire logic low_power_internal_rc_i,
	// clock enables and instruction clock out
	output logic sys_tick_o,
	output logic instr_tick_o,
	output logic instruction_clock_o,
	output logic wdt_ref_tick_o,
	// oscillator controls
	output logic xtal_amp_en_o,
	output logic xtal_high_gain_o,
	output logic sec_osc_en_o,
	output logic pll_en_o,
	output logic osc2_clkout_o,
	output logic osc2_clkout_en_o
);

	// divider helpers
	function automatic logic [8:0] rc_div_f(input logic [2:0] sel);
		rc_div_f = scs_pkg::RC_BASE << sel;
	endfunction

	function automatic logic [8:0] pll_den_f(input logic [4:0] pre, input logic [1:0] pst);
		logic [8:0] n1;
		logic [1:0] sh;
		n1 = {4'h0, pre} + scs_pkg::PRE_BASE;
		case (pst)
			2'h0: sh = scs_pkg::SH_N2_2;
			2'h1: sh = scs_pkg::SH_N2_4;
			default: sh = scs_pkg::SH_N2_8;
		endcase
		pll_den_f = n1 << sh;
	endfunction

	function automatic logic is_pri_f(input scs_pkg::scs_src_e s);
		is_pri_f = (s == scs_pkg::SRC_PRIMARY) || (s == scs_pkg::SRC_PRIMARY_PLL);
	endfunction

	function automatic logic is_pll_f(input scs_pkg::scs_src_e s);
		is_pll_f = (s == scs_pkg::SRC_RC_PLL) || (s == scs_pkg::SRC_PRIMARY_PLL);
	endfunction

	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] last_r;
	logic [3:0] edge_w;
	logic [2:0] rcp_r;
	logic [1:0] pst_r;
	logic [4:0] pre_r;
	logic [8:0] fbd_r;
	scs_pkg::scs_src_e cur_src_r;
	scs_pkg::scs_src_e req_src_r;
	scs_pkg::scs_state_e state_r;
	logic [8:0] rc_cnt_r;
	logic [8:0] rc_lim;
	logic rc_tick;
	logic [15:0] acc_r;
	logic [15:0] acc_nxt;
	logic [8:0] den;
	logic [9:0] mul;
	logic pll_in_edge;
	logic pll_tick;
	logic fosc_tick;
	logic phase_r;
	logic instr_tick_nxt;
	logic switch_now;
	logic div_wr;
	logic pri_used;
	logic pri_xtal;
	logic [scs_pkg::DATA_W-1:0] rdata_r;
	logic sys_tick_r;
	logic instr_tick_r;
	logic wdt_tick_r;
	logic amp_r;
	logic gain_r;
	logic sec_en_r;
	logic pll_en_r;
	logic clkout_en_r;

	// pins are asynchronous: two flops, then edge detect on the second
	always_ff @(posedge clk_i) begin
		sync1_r <= {low_power_internal_rc_i, secondary_osc_i, primary_osc_i, fast_internal_rc_i};
		sync2_r <= sync1_r;
		last_r <= sync2_r;
	end
	assign edge_w = sync2_r & ~last_r;

	// divisor and feedback registers
	assign div_wr = we_i && (addr_i == scs_pkg::OFS_DIV);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rcp_r <= scs_pkg::RCP_RST;
			pst_r <= scs_pkg::PST_RST;
			pre_r <= scs_pkg::PRE_RST;
			fbd_r <= scs_pkg::FBD_RST;
		end else if (div_wr) begin
			rcp_r <= wdata_i[scs_pkg::RCP_MSB:scs_pkg::RCP_LSB];
			pst_r <= wdata_i[scs_pkg::PST_MSB:scs_pkg::PST_LSB];
			pre_r <= wdata_i[scs_pkg::PRE_MSB:scs_pkg::PRE_LSB];
		end else if (we_i && (addr_i == scs_pkg::OFS_FBD)) begin
			fbd_r <= wdata_i[scs_pkg::FBD_MSB:0];
		end
	end

	// read data only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i || !re_i) begin
			rdata_r <= '0;
		end else begin
			case (addr_i)
				scs_pkg::OFS_DIV: rdata_r <= {5'h00, rcp_r, pst_r, 1'b0, pre_r};
				scs_pkg::OFS_FBD: rdata_r <= {7'h00, fbd_r};
				scs_pkg::OFS_SRC: rdata_r <= {8'h00, state_r == scs_pkg::ST_SWITCH,
					cur_src_r, 1'b0, req_src_r};
				default: rdata_r <= '0;
			endcase
		end
	end

	// source selection: configuration at reset, then glitch-free switching
	assign switch_now = (state_r == scs_pkg::ST_SWITCH) && instr_tick_nxt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_src_r <= scs_pkg::scs_src_e'(initial_source_sel_i);
			req_src_r <= scs_pkg::scs_src_e'(initial_source_sel_i);
			state_r <= scs_pkg::ST_RUN;
		end else begin
			case (state_r)
				scs_pkg::ST_RUN: state_r <= scs_pkg::ST_RUN;
				scs_pkg::ST_SWITCH: begin
					// only at the end of a full instruction period
					if (instr_tick_nxt) begin
						cur_src_r <= req_src_r;
						state_r <= scs_pkg::ST_RUN;
					end
				end
				default: state_r <= scs_pkg::ST_RUN;
			endcase
			// a new request wins over completion of the old one
			if (we_i && (addr_i == scs_pkg::OFS_SRC)) begin
				req_src_r <= scs_pkg::scs_src_e'(wdata_i[scs_pkg::REQ_MSB:scs_pkg::REQ_LSB]);
				state_r <= scs_pkg::ST_SWITCH;
			end
		end
	end

	// RC postscaler; cleared on switch so the first divided period is whole
	assign rc_lim = (cur_src_r == scs_pkg::SRC_RC_DIV16) ? scs_pkg::RC_DIV16 :
		rc_div_f(rcp_r);
	assign rc_tick = edge_w[scs_pkg::PIN_RC] && (rc_cnt_r >= rc_lim - 9'h001);
	always_ff @(posedge clk_i) begin
		if (rst_i || switch_now || div_wr) begin
			rc_cnt_r <= '0;
		end else if (edge_w[scs_pkg::PIN_RC] && ((cur_src_r == scs_pkg::SRC_RC_DIV16) ||
			(cur_src_r == scs_pkg::SRC_RC_POST))) begin
			rc_cnt_r <= rc_tick ? 9'h000 : rc_cnt_r + 9'h001;
		end
	end

	// PLL as a rate synthesiser: each input edge adds M, each output tick takes N1*N2
	assign pll_in_edge = (cur_src_r == scs_pkg::SRC_RC_PLL) ? edge_w[scs_pkg::PIN_RC] :
		(cur_src_r == scs_pkg::SRC_PRIMARY_PLL) ? edge_w[scs_pkg::PIN_PRI] : 1'b0;
	assign den = pll_den_f(pre_r, pst_r);
	assign mul = {1'b0, fbd_r} + scs_pkg::FBD_BASE;
	assign pll_tick = acc_r >= {7'h00, den};
	always_comb begin
		logic [16:0] sum;
		sum = {1'b0, acc_r} + (pll_in_edge ? {7'h00, mul} : 17'h00000);
		// saturate: output beyond one tick per cycle cannot be represented
		acc_nxt = sum[16] ? scs_pkg::ACC_MAX : sum[15:0];
		if (pll_tick) begin
			acc_nxt = acc_nxt - {7'h00, den};
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || switch_now) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// oscillator tick of the current source
	always_comb begin
		case (cur_src_r)
			scs_pkg::SRC_RC: fosc_tick = edge_w[scs_pkg::PIN_RC];
			scs_pkg::SRC_RC_PLL: fosc_tick = pll_tick;
			scs_pkg::SRC_PRIMARY: fosc_tick = edge_w[scs_pkg::PIN_PRI];
			scs_pkg::SRC_PRIMARY_PLL: fosc_tick = pll_tick;
			scs_pkg::SRC_SECONDARY: fosc_tick = edge_w[scs_pkg::PIN_SEC];
			scs_pkg::SRC_LP_RC: fosc_tick = edge_w[scs_pkg::PIN_LP];
			default: fosc_tick = rc_tick;
		endcase
	end

	// divide by two for the instruction clock
	assign instr_tick_nxt = fosc_tick && phase_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r <= 1'b0;
		end else if (fosc_tick) begin
			phase_r <= !phase_r;
		end
	end

	// keep the outgoing and incoming oscillators both alive while switching
	assign pri_used = is_pri_f(cur_src_r) ||
		((state_r == scs_pkg::ST_SWITCH) && is_pri_f(req_src_r));
	assign pri_xtal = pri_used && ((primary_mode_sel_i == scs_pkg::PM_STD_XTAL) ||
		(primary_mode_sel_i == scs_pkg::PM_FAST_XTAL));

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_tick_r <= 1'b0;
			instr_tick_r <= 1'b0;
			wdt_tick_r <= 1'b0;
			amp_r <= 1'b0;
			gain_r <= 1'b0;
			sec_en_r <= 1'b0;
			pll_en_r <= 1'b0;
			clkout_en_r <= 1'b0;
		end else begin
			sys_tick_r <= fosc_tick;
			instr_tick_r <= instr_tick_nxt;
			wdt_tick_r <= edge_w[scs_pkg::PIN_LP];
			amp_r <= pri_xtal;
			gain_r <= pri_xtal && (primary_mode_sel_i == scs_pkg::PM_FAST_XTAL);
			sec_en_r <= (cur_src_r == scs_pkg::SRC_SECONDARY) ||
				(req_src_r == scs_pkg::SRC_SECONDARY);
			pll_en_r <= is_pll_f(cur_src_r) || is_pll_f(req_src_r);
			// a crystal owns the pin; otherwise the configuration bit decides
			clkout_en_r <= !pri_xtal && !osc_pin_function_bit_i;
		end
	end
	assign rdata_o = rdata_r;
	assign sys_tick_o = sys_tick_r;
	assign instr_tick_o = instr_tick_r;
	assign instruction_clock_o = phase_r;
	assign osc2_clkout_o = phase_r;
	assign wdt_ref_tick_o = wdt_tick_r;
	assign xtal_amp_en_o = amp_r;
	assign xtal_high_gain_o = gain_r;
	assign sec_osc_en_o = sec_en_r;
	assign pll_en_o = pll_en_r;
	assign osc2_clkout_en_o = clkout_en_r;

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_src_change;
		!$stable(cur_src_r) ##0 !$past(rst_i);
	endsequence

	AST_INSTR_HALF: assert property (instr_tick_o |-> sys_tick_o && !instruction_clock_o)
		else $error("instruction tick not on a falling half of the oscillator");
	AST_RC_POST: assert property ((cur_src_r == scs_pkg::SRC_RC_POST) |->
		rc_cnt_r < rc_div_f(rcp_r))
		else $error("postscaler count beyond selected factor");
	// the written prescale field lands whole, and any field value stays within 2 to 33
	AST_PRE_RANGE: assert property (div_wr |=>
		pre_r == $past(wdata_i[scs_pkg::PRE_MSB:scs_pkg::PRE_LSB]) &&
		{4'h0, pre_r} + scs_pkg::PRE_BASE <= scs_pkg::N1_MAX)
		else $error("prescale field not taken or outside 2 to 33");
	AST_FBD_LOAD: assert property ((we_i && addr_i == scs_pkg::OFS_FBD) |=>
		mul == {1'b0, $past(wdata_i[scs_pkg::FBD_MSB:0])} + scs_pkg::FBD_BASE)
		else $error("feedback factor not taken from write");
	AST_POST_SET: assert property (den == {4'h0, pre_r} + scs_pkg::PRE_BASE << 1 ||
		den == {4'h0, pre_r} + scs_pkg::PRE_BASE << 2 ||
		den == {4'h0, pre_r} + scs_pkg::PRE_BASE << 3)
		else $error("postscale factor not 2, 4 or 8");
	// leaving a pll source clears the accumulator on a tick, so that edge is left out
	AST_PLL_BAL: assert property (pll_tick && !pll_in_edge && !switch_now |=>
		acc_r == $past(acc_r) - {7'h00, $past(den)})
		else $error("pll accumulator lost balance");
	AST_PLL_SRC: assert property (pll_in_edge |->
		edge_w[scs_pkg::PIN_RC] || edge_w[scs_pkg::PIN_PRI])
		else $error("pll fed from a disallowed source");
	AST_POR_SRC: assert property ($past(rst_i) |->
		cur_src_r == scs_pkg::scs_src_e'($past(initial_source_sel_i)))
		else $error("source not loaded from configuration at reset");
	AST_XTAL_MODE: assert property (xtal_high_gain_o |-> xtal_amp_en_o)
		else $error("fast crystal gain without amplifier");
	AST_WDT_REF: assert property (edge_w[scs_pkg::PIN_LP] |=> wdt_ref_tick_o)
		else $error("low-power reference tick missing");
	AST_OSC2_PIN: assert property ($past(osc_pin_function_bit_i) |-> !osc2_clkout_en_o)
		else $error("clock driven on pin reserved by configuration");
	AST_NO_RUNT: assert property (s_src_change |-> instr_tick_o && !instruction_clock_o)
		else $error("source changed mid period");

	// a source write must open a switch even when an older one is just completing
	sequence s_switch_req;
		we_i && (addr_i == scs_pkg::OFS_SRC);
	endsequence

	AST_SWITCH_BUSY: assert property (s_switch_req |=>
		state_r == scs_pkg::ST_SWITCH)
		else $error("source request did not start a switch");
	// source and enable checks
	AST_DIRECT_PRI: assert property (cur_src_r == scs_pkg::SRC_PRIMARY &&
		edge_w[scs_pkg::PIN_PRI] |=> sys_tick_o)
		else $error("primary edge did not reach the system tick");
	AST_DIV16: assert property (cur_src_r == scs_pkg::SRC_RC_DIV16 |->
		rc_cnt_r < scs_pkg::RC_DIV16)
		else $error("divide-by-16 count out of range");
	AST_NOT_PRI: assert property (!pri_used |=> !xtal_amp_en_o)
		else $error("crystal amplifier on for a non-primary source");
	AST_PLL_ON: assert property (is_pll_f(cur_src_r) |=> pll_en_o)
		else $error("pll disabled while feeding the clock");
	AST_SEC_ON: assert property (cur_src_r == scs_pkg::SRC_SECONDARY |=>
		sec_osc_en_o)
		else $error("secondary oscillator off while selected");

endmodule

// ### verification/scs_osc_model.sv
`timescale 1ns/1ps
// free-running oscillators; edges land just after a clock edge so the
// design's synchroniser sees them on known cycles
module scs_osc_model #(
	parameter int HP_RC = 2,
	parameter int HP_PRI = 4,
	parameter int HP_SEC = 6,
	parameter int HP_LP = 8
) (
	// clock
	input wire logic clk_i,
	// oscillator waveforms
	output logic rc_o,
	output logic pri_o,
	output logic sec_o,
	output logic lp_o
);
	int n = 0;
	// oscillators never pause, so the time base just keeps counting
	always @(posedge clk_i) begin
		n <= n + 1;
	end
	// distinct periods let the bench tell which pin feeds the output
	assign rc_o = 1'((n / HP_RC) % 2);
	assign pri_o = 1'((n / HP_PRI) % 2);
	assign sec_o = 1'((n / HP_SEC) % 2);
	assign lp_o = 1'((n / HP_LP) % 2);
endmodule

// ### verification/test_scs_clock_source.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module test_scs_clock_source;
	localparam int W = 960;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic [2:0] init_sel = 3'h7;
	logic [1:0] pmode = 2'h0;
	logic pin_fn = 1'b0;
	logic [15:0] rdata_o, r;
	logic rc, pri, sec, lp, st, it, ic, wt, amp, gain, sen, pen, ck2, ck2_en, ea, eg;
	logic ph = 1'b0;
	int fails = 0;
	int num_checks = 0;
	int seed = 32'hd8072d1e;
	int cyc = 0, sl = 0, sys_per = 0, sys_cnt = 0, il = 0, ins_per = 0, wl = 0, wdt_per = 0;
	int d, e, c, k;
	// source, divisor, feedback, mode; PLL rows keep every stage in band at 40 MHz
	int t_src[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 3};
	int t_div[9] = '{0, 'hC1, 0, 'h40, 0, 0, 0, 0, 'h80};
	int t_fbd[9] = '{'h1E, 'h2E, 'h1E, 'h32, 'h1E, 'h1E, 'h1E, 'h1E, 'h3E};
	int t_md[9] = '{2, 1, 1, 2, 2, 1, 2, 1, 0};
	scs_osc_model scs_osc_model_inst (.clk_i(clk_i), .rc_o(rc), .pri_o(pri), .sec_o(sec),
		.lp_o(lp));
	scs_clock_source scs_clock_source_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.initial_source_sel_i(init_sel), .primary_mode_sel_i(pmode),
		.osc_pin_function_bit_i(pin_fn), .fast_internal_rc_i(rc), .primary_osc_i(pri),
		.secondary_osc_i(sec), .low_power_internal_rc_i(lp), .sys_tick_o(st),
		.instr_tick_o(it), .instruction_clock_o(ic), .wdt_ref_tick_o(wt),
		.xtal_amp_en_o(amp), .xtal_high_gain_o(gain), .sec_osc_en_o(sen), .pll_en_o(pen),
		.osc2_clkout_o(ck2), .osc2_clkout_en_o(ck2_en));
	// 40 MHz clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// tick gaps and counts, measured in clock cycles
	always @(posedge clk_i) begin
		cyc++;
		if (st === 1'b1) begin
			sys_per = cyc - sl;
			sl = cyc;
			sys_cnt++;
		end
		if (it === 1'b1) begin
			ins_per = cyc - il;
			il = cyc;
		end
		if (wt === 1'b1) begin
			wdt_per = cyc - wl;
			wl = cyc;
		end
		// instruction clock model: starts low and flips on every oscillator tick
		if (rst_i === 1'b1) begin
			ph = 1'b0;
		end else if (st === 1'b1) begin
			ph = ~ph;
			`CHK("instr clock", ph, ic)
			`CHK("osc2 clock out", ph, ck2)
		end
	end
	// expected tick gap for direct sources, ticks per W cycles for PLL ones
	function automatic int model(int s, int dv, int f);
		int n2;
		n2 = ((dv >> 6) & 3) == 0 ? 2 : (((dv >> 6) & 3) == 1 ? 4 : 8);
		case (s)
			1: return W * (f + 2) / (((dv & 31) + 2) * n2 * 4);
			3: return W * (f + 2) / (((dv & 31) + 2) * n2 * 8);
			2: return 8;
			4: return 12;
			5: return 16;
			6: return 64;
			7: return (2 << ((dv >> 8) & 7)) * 4;
			default: return 4;
		endcase
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1;
		r = rdata_o;
	endtask
	task automatic do_reset(input logic [2:0] s);
		@(posedge clk_i);
		rst_i <= 1'b1;
		init_sel <= s;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// limit sized well above the longest switch and measurement sum
	initial begin
		repeat (90000) @(posedge clk_i);
		fails++;
		give_verdict();
	end
	initial begin
		do_reset(3'h7);
		rd(scs_pkg::OFS_DIV);
		`CHK("div reset", 16'h0000, r)
		rd(scs_pkg::OFS_FBD);
		`CHK("fbd reset", 16'h001E, r)
		rd(scs_pkg::OFS_SRC);
		`CHK("src reset", 16'h0077, r)
		rd(4'hC);
		`CHK("unmapped", 16'h0000, r)
		repeat (60) @(posedge clk_i);
		`CHK("erased period", 8, sys_per)
		for (int i = 0; i < 9; i++) begin
			d = t_src[i] == 7 ? ($random(seed) & 7) << 8 : t_div[i];
			pmode <= 2'(t_md[i]);
			pin_fn <= 1'($random(seed));
			wr(scs_pkg::OFS_DIV, 16'(d));
			wr(scs_pkg::OFS_FBD, 16'(t_fbd[i]));
			rd(scs_pkg::OFS_DIV);
			`CHK("div readback", 16'(d), r)
			wr(scs_pkg::OFS_SRC, 16'(t_src[i]));
			k = 0;
			r = 16'h0080;
			while (r[7] !== 1'b0 && k < 1500) begin
				rd(scs_pkg::OFS_SRC);
				k++;
			end
			`CHK("current source", 3'(t_src[i]), r[6:4])
			e = model(t_src[i], d, t_fbd[i]);
			if (t_src[i] == 1 || t_src[i] == 3) begin
				repeat (100) @(posedge clk_i);
				#1;
				c = sys_cnt;
				repeat (W) @(posedge clk_i);
				#1;
				c = sys_cnt - c;
				`CHK("pll ticks", 1, int'(c >= e - 1 && c <= e + 1))
			end else begin
				repeat (5 * e + 40) @(posedge clk_i);
				`CHK("sys period", e, sys_per)
				`CHK("instr period", 2 * e, ins_per)
			end
			ea = (t_src[i] == 2 || t_src[i] == 3) && t_md[i] != 0;
			eg = ea && t_md[i] == 2;
			`CHK("amp", ea, amp)
			`CHK("gain", eg, gain)
			`CHK("sec en", 1'(t_src[i] == 4), sen)
			`CHK("pll en", 1'(t_src[i] == 1 || t_src[i] == 3), pen)
			`CHK("osc2 en", ~ea & ~pin_fn, ck2_en)
			`CHK("wdt period", 16, wdt_per)
		end
		do_reset(3'h2);
		rd(scs_pkg::OFS_SRC);
		`CHK("src after reset", 16'h0022, r)
		repeat (60) @(posedge clk_i);
		`CHK("primary period", 8, sys_per)
		give_verdict();
	end
endmodule
